// >>> rtl/llc_low_power_burst_sequencer.sv
// low-power cycle, mode and burst sequencer with AHB-Lite register slave
`timescale 1ns/1ps
module llc_low_power_burst_sequencer #(
   parameter int unsigned BURST_BASE_CYCLES = llc_pkg::BURST_BASE_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic node_top_pin,
   input wire logic cap_sense_hit_pin,
   input wire logic [2:0] mode_preset_pin,
   input wire logic [1:0] burst_rate_preset_pin,
   output logic upper_switch_drive,
   output logic lower_switch_drive,
   output logic [7:0] cycle_energy
);
   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
      logic top_d;
      logic cap_d;
      logic ap_v;
      logic ap_w;
      logic [4:0] ap_a;
      logic ready;
      logic [31:0] rdata;
      logic enable;
      logic [7:0] demand;
      logic run;
      logic load;
      llc_pkg::seq_state_t st;
      llc_pkg::op_mode_t mode;
      logic upper;
      logic lower;
      logic [7:0] tmr;
      logic [7:0] wait_cnt;
      logic [7:0] wait_tgt;
      logic [3:0] frac;
      logic [11:0] period;
      logic [17:0] burst_tmr;
      logic [7:0] burst_n;
      logic [7:0] burst_left;
      logic [7:0] energy;
   } core_t;

   core_t q;
   core_t n;
   logic top_evt;
   logic cap_evt;
   logic [7:0] thr;
   logic [7:0] emin;
   logic [7:0] exit_lvl;
   logic [1:0] rate;
   logic [8:0] ec9;
   logic [7:0] deficit;
   logic [9:0] wq;
   logic [4:0] acc;
   logic [7:0] n_tgt;
   logic [17:0] burst_reload;
   logic [31:0] rd;

   // resonance tops and cap-sense hits only ever seen after two flops
   assign top_evt = q.s2[6] & ~q.top_d;
   assign cap_evt = q.s2[5] & ~q.cap_d;

   preset_decoder u_presets (
      .clk(clk),
      .rst_b(rst_b),
      .load(q.load),
      .mode_code(q.s2[4:2]),
      .rate_code(q.s2[1:0]),
      .power_thresh(thr),
      .min_cycle_energy(emin),
      .exit_level(exit_lvl),
      .burst_rate(rate)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = q;
      ec9 = {1'b0, q.demand} + {2'h0, q.demand[7:llc_pkg::LOW_ENERGY_SHIFT]};
      deficit = emin - ec9[7:0];
      wq = {deficit, 2'h0};
      acc = {1'b0, q.frac} + {1'b0, wq[3:0]};
      n_tgt = {1'b0, q.demand[7:1]} + 8'h01;
      burst_reload = 18'(BURST_BASE_CYCLES << (2'h3 - rate));
      rd = 32'h0;
      case (haddr[4:0])
         llc_pkg::A_CTRL: rd = {31'h0, q.enable};
         llc_pkg::A_DEMAND: rd = {24'h0, q.demand};
         llc_pkg::A_STATUS: rd = {16'h0, q.energy, 1'b0, q.run, q.mode, q.upper,
            q.st};
         llc_pkg::A_PRESET: rd = {6'h0, rate, exit_lvl, emin, thr};
         llc_pkg::A_WAIT: rd = {q.burst_left, q.burst_n, q.wait_cnt, q.wait_tgt};
         default: rd = 32'h0;
      endcase
      n.s1 = {node_top_pin, cap_sense_hit_pin, mode_preset_pin,
         burst_rate_preset_pin};
      n.s2 = q.s1;
      n.top_d = q.s2[6];
      n.cap_d = q.s2[5];
      n.load = 1'b0;
      // zero-wait slave: writes land in the data phase, reads sample at address
      n.ready = 1'b1;
      if (q.ap_v && q.ap_w) begin
         case (q.ap_a)
            llc_pkg::A_CTRL: n.enable = hwdata[0];
            llc_pkg::A_DEMAND: n.demand = hwdata[7:0];
            default: ;
         endcase
      end
      n.ap_v = hsel && htrans[1] && hready;
      n.ap_w = hwrite;
      n.ap_a = haddr[4:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
         n.rdata = rd;
      end
      if (q.period != 12'hfff) begin
         n.period = q.period + 12'h001;
      end
      if (q.burst_tmr != 18'h0) begin
         n.burst_tmr = q.burst_tmr - 18'h00001;
      end
      if (!q.enable) begin
         n.run = 1'b0;
         n.st = llc_pkg::s_idle;
         n.upper = 1'b0;
         n.lower = 1'b0;
      end else if (!q.run) begin
         // presets sampled while the bridge is still quiet
         n.run = 1'b1;
         n.load = 1'b1;
         n.mode = llc_pkg::continuous_switching_mode;
         n.wait_tgt = llc_pkg::RST_WAIT;
         n.burst_n = llc_pkg::RST_BURST_N;
         n.frac = 4'h0;
      end else begin
         case (q.st)
            llc_pkg::s_idle: begin
               if (!q.load && (q.mode != llc_pkg::grouped_pulse_mode ||
                     q.burst_tmr == 18'h0)) begin
                  if (q.mode == llc_pkg::grouped_pulse_mode) begin
                     n.burst_tmr = burst_reload;
                     n.burst_left = q.burst_n;
                     // one step per burst toward the demand, period unchanged
                     if (q.burst_n < n_tgt) begin
                        n.burst_n = q.burst_n + 8'h01;
                     end else if (q.burst_n > n_tgt) begin
                        n.burst_n = q.burst_n - 8'h01;
                     end
                  end
                  n.st = llc_pkg::s_conv1;
                  n.lower = 1'b1;
                  n.period = 12'h0;
               end
            end
            llc_pkg::s_conv1: begin
               if (cap_evt) begin
                  n.lower = 1'b0;
                  n.upper = 1'b1;
                  n.st = llc_pkg::s_conv2;
               end
            end
            llc_pkg::s_conv2: begin
               if (cap_evt) begin
                  n.upper = 1'b0;
                  n.lower = 1'b1;
                  if (q.mode == llc_pkg::continuous_switching_mode &&
                        q.demand >= thr) begin
                     n.st = llc_pkg::s_conv1;
                     n.energy = q.demand;
                  end else begin
                     if (q.mode == llc_pkg::continuous_switching_mode) begin
                        n.mode = llc_pkg::energy_control_submode;
                        n.energy = ec9[8] ? 8'hff : ec9[7:0];
                     end
                     n.st = llc_pkg::s_prep;
                  end
               end
            end
            llc_pkg::s_prep: begin
               if (cap_evt) begin
                  n.lower = 1'b0;
                  n.upper = 1'b1;
                  n.tmr = 8'(llc_pkg::DUMP_CYC - 1);
                  n.st = llc_pkg::s_dump;
               end
            end
            llc_pkg::s_dump: begin
               if (q.tmr != 8'h0) begin
                  n.tmr = q.tmr - 8'h01;
               end else begin
                  n.upper = 1'b0;
                  n.wait_cnt = 8'h0;
                  n.st = llc_pkg::s_wait;
                  if (q.demand >= thr) begin
                     n.mode = llc_pkg::continuous_switching_mode;
                     n.energy = q.demand;
                  end else if (q.mode == llc_pkg::grouped_pulse_mode &&
                        q.demand < exit_lvl) begin
                     // wait target left alone: frozen at burst entry
                     n.energy = emin;
                     n.burst_left = q.burst_left - 8'h01;
                     if (q.burst_left <= 8'h01) begin
                        n.st = llc_pkg::s_idle;
                     end
                  end else if (ec9 >= {1'b0, emin}) begin
                     n.mode = llc_pkg::energy_control_submode;
                     n.energy = ec9[8] ? 8'hff : ec9[7:0];
                     n.wait_tgt = llc_pkg::RST_WAIT;
                     n.frac = 4'h0;
                  end else begin
                     n.mode = llc_pkg::rate_control_submode;
                     n.energy = emin;
                     // fraction carry alternates between two whole counts
                     n.frac = acc[3:0];
                     n.wait_tgt = llc_pkg::RST_WAIT + {2'h0, wq[9:4]} +
                        {7'h0, acc[4]};
                  end
               end
            end
            llc_pkg::s_wait: begin
               if (top_evt) begin
                  if (q.wait_cnt + 8'h01 >= q.wait_tgt) begin
                     n.upper = 1'b1;
                     n.tmr = 8'(llc_pkg::RESTORE_CYC - 1);
                     n.st = llc_pkg::s_restore;
                  end else begin
                     n.wait_cnt = q.wait_cnt + 8'h01;
                  end
               end
            end
            llc_pkg::s_restore: begin
               if (q.tmr != 8'h0) begin
                  n.tmr = q.tmr - 8'h01;
               end else begin
                  n.upper = 1'b0;
                  n.lower = 1'b1;
                  n.period = 12'h0;
                  n.st = llc_pkg::s_conv1;
                  if (q.mode == llc_pkg::rate_control_submode &&
                        q.period >= 12'(llc_pkg::GROUP_ENTRY_CYC)) begin
                     n.mode = llc_pkg::grouped_pulse_mode;
                     n.burst_tmr = burst_reload;
                     n.burst_left = q.burst_n;
                  end
               end
            end
            default: begin
               n.st = llc_pkg::s_idle;
               n.upper = 1'b0;
               n.lower = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = q.ready;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign upper_switch_drive = q.upper;
   assign lower_switch_drive = q.lower;
   assign cycle_energy = q.energy;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence leave_dump;
      q.st == llc_pkg::s_dump ##1 q.st != llc_pkg::s_dump;
   endsequence
   sequence enter_restore;
      q.st != llc_pkg::s_restore ##1 q.st == llc_pkg::s_restore;
   endsequence

   chk_cycle_order: assert property (leave_dump |->
      q.st == llc_pkg::s_wait || q.st == llc_pkg::s_idle || !q.enable)
      else $error("dump not followed by wait");
   chk_wait_gates: assert property (q.st == llc_pkg::s_wait |->
      !q.upper && !q.lower)
      else $error("gate on while waiting");
   chk_restore_top: assert property (enter_restore |-> $past(top_evt))
      else $error("restore began off a top");
   chk_wait_min: assert property (enter_restore |->
      $past(q.wait_cnt) + 8'h01 >= q.wait_tgt && q.wait_tgt != 8'h0)
      else $error("wait shorter than one resonance");
   chk_restore_pulse: assert property (enter_restore |->
      (q.upper && !q.lower)[*6] ##1 (!q.upper || !q.enable))
      else $error("restore pulse length wrong");
   chk_rate_energy: assert property (q.st == llc_pkg::s_conv1 &&
      q.mode == llc_pkg::rate_control_submode |-> q.energy == emin)
      else $error("rate submode energy not minimum");
   chk_wait_step: assert property ($changed(q.wait_tgt) |->
      $past(q.st) == llc_pkg::s_dump || !$past(q.run))
      else $error("wait target moved mid-cycle");
   chk_burst_frozen: assert property (q.mode == llc_pkg::grouped_pulse_mode &&
      $past(q.mode) == llc_pkg::grouped_pulse_mode |-> $stable(q.wait_tgt))
      else $error("wait changed inside burst mode");
   chk_burst_entry: assert property ($changed(q.mode) &&
      q.mode == llc_pkg::grouped_pulse_mode |->
      $past(q.period) >= 12'(llc_pkg::GROUP_ENTRY_CYC))
      else $error("burst entered above 23 kHz");
   chk_entry_energy: assert property ($changed(q.mode) &&
      q.mode == llc_pkg::energy_control_submode &&
      $past(q.mode) == llc_pkg::continuous_switching_mode |->
      q.energy >= q.demand)
      else $error("energy not raised on entry");
endmodule

// >>> rtl/llc_pkg.sv
// shared constants, tables and types for the low-power burst sequencer
package llc_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_MHZ = 40;
   // shortened high-side pulses, least times rounded up
   localparam int DUMP_ON_NS = 100;
   localparam int RESTORE_ON_NS = 150;
   localparam int DUMP_CYC = (DUMP_ON_NS * CLK_MHZ + 999) / 1000;
   localparam int RESTORE_CYC = (RESTORE_ON_NS * CLK_MHZ + 999) / 1000;
   // repetition rate at which grouped pulse operation takes over
   localparam int GROUP_ENTRY_HZ = 23_000;
   localparam int GROUP_ENTRY_CYC = CLK_HZ / GROUP_ENTRY_HZ;
   // fastest burst rate; slower rates are this period shifted left
   localparam int BURST_MAX_HZ = 1600;
   localparam int BURST_BASE_CYC = CLK_HZ / BURST_MAX_HZ;
   // power figures are in half-percent of nominal
   localparam logic [7:0] THRESH_TBL [0:3] = '{8'h32, 8'h4b, 8'h64, 8'h7d};
   // one word per resistor code, byte n for burst rate code n
   localparam logic [31:0] MIN_ENERGY_TBL [0:7] = '{
      32'h0a0a0a0a, 32'h12121212, 32'h0c0a0a0a, 32'h16121212,
      32'h120e0c0a, 32'h221c1412, 32'h16120e0a, 32'h2e241c12};
   localparam logic [31:0] EXIT_LVL_TBL [0:7] = '{
      32'h12121212, 32'h18181818, 32'h14121212, 32'h1a181818,
      32'h18161412, 32'h221e1a18, 32'h1c181412, 32'h28231e18};
   localparam int LOW_ENERGY_SHIFT = 1;
   localparam int WAIT_GAIN_SHIFT = 2;
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_DEMAND = 5'h04;
   localparam logic [4:0] A_STATUS = 5'h08;
   localparam logic [4:0] A_PRESET = 5'h0c;
   localparam logic [4:0] A_WAIT = 5'h10;
   localparam logic [7:0] RST_WAIT = 8'h01;
   localparam logic [7:0] RST_BURST_N = 8'h01;
   typedef enum logic [2:0] {
      s_idle = 3'h0, s_conv1 = 3'h1, s_conv2 = 3'h3, s_prep = 3'h2,
      s_dump = 3'h6, s_wait = 3'h7, s_restore = 3'h5
   } seq_state_t;
   typedef enum logic [1:0] {
      continuous_switching_mode = 2'h0, energy_control_submode = 2'h1,
      rate_control_submode = 2'h3, grouped_pulse_mode = 2'h2
   } op_mode_t;
endpackage

// >>> rtl/preset_decoder.sv
// resistor code decoder that holds presets between starts
`timescale 1ns/1ps
module preset_decoder (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [2:0] mode_code,
   input wire logic [1:0] rate_code,
   output logic [7:0] power_thresh,
   output logic [7:0] min_cycle_energy,
   output logic [7:0] exit_level,
   output logic [1:0] burst_rate
);
   typedef struct packed {
      logic [7:0] thr;
      logic [7:0] emin;
      logic [7:0] exit;
      logic [1:0] rate;
   } pre_t;
   pre_t q;
   pre_t n;
   logic [31:0] e_row;
   logic [31:0] x_row;

   always_comb begin
      n = q;
      e_row = llc_pkg::MIN_ENERGY_TBL[mode_code];
      x_row = llc_pkg::EXIT_LVL_TBL[mode_code];
      if (load) begin
         n.thr = llc_pkg::THRESH_TBL[mode_code[2:1]];
         n.emin = e_row[{rate_code, 3'h0} +: 8];
         n.exit = x_row[{rate_code, 3'h0} +: 8];
         n.rate = rate_code;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign power_thresh = q.thr;
   assign min_cycle_energy = q.emin;
   assign exit_level = q.exit;
   assign burst_rate = q.rate;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_preset_hold: assert property (!$past(load) |-> $stable(q))
      else $error("presets changed outside a start");
   chk_thresh_decode: assert property ($past(load) |->
      power_thresh == llc_pkg::THRESH_TBL[$past(mode_code[2:1])])
      else $error("power threshold decode wrong");
endmodule

// >>> test/half_bridge_stage_model.sv
// behavioural half-bridge stage: cap-sense hits while a gate conducts, node tops while idle
`timescale 1ns/1ps
module half_bridge_stage_model (
   input wire logic clk,
   input wire logic upper_switch_drive,
   input wire logic lower_switch_drive,
   input wire logic [15:0] top_gap,
   output logic node_top_pin,
   output logic cap_sense_hit_pin
);
   // comparator trips this many cycles after a gate turns on
   localparam int HIT_CYC = 20;
   // one process drives each output; pins settle on the first edge, well inside reset
   int on_cnt = 0;
   int off_cnt = 0;
   logic [1:0] gates_q = 2'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // short dump and restore pulses end before the comparator trips, so they draw no hit
   always @(posedge clk) begin
      gates_q <= {upper_switch_drive, lower_switch_drive};
      if (upper_switch_drive || lower_switch_drive) begin
         on_cnt <= (gates_q != {upper_switch_drive, lower_switch_drive}) ? 0 : on_cnt + 1;
         off_cnt <= 0;
      end else begin
         on_cnt <= 0;
         off_cnt <= (off_cnt + 1 >= int'(top_gap)) ? 0 : off_cnt + 1;
      end
      cap_sense_hit_pin <= (on_cnt >= HIT_CYC) && (on_cnt < HIT_CYC + 3);
      // the node rings freely while both switches are off: one top per resonance cycle
      node_top_pin <= !(upper_switch_drive || lower_switch_drive)
         && (off_cnt + 2 >= int'(top_gap));
   end
endmodule

// >>> test/llc_low_power_burst_sequencer_tb.sv
// self-checking bench for the low-power burst sequencer
`timescale 1ns/1ps
module llc_low_power_burst_sequencer_tb;
   typedef struct packed {
      logic [2:0] mode;
      logic [7:0] thr;
      logic [31:0] ec;
      logic [31:0] ex;
   } row_t;
   // power in half-percent; byte n of ec and ex belongs to burst rate code n
   localparam row_t ROWS [0:7] = '{
      '{3'h0, 8'h32, 32'h0a0a0a0a, 32'h12121212}, '{3'h1, 8'h32, 32'h12121212, 32'h18181818},
      '{3'h2, 8'h4b, 32'h0c0a0a0a, 32'h14121212}, '{3'h3, 8'h4b, 32'h16121212, 32'h1a181818},
      '{3'h4, 8'h64, 32'h120e0c0a, 32'h18161412}, '{3'h5, 8'h64, 32'h221c1412, 32'h221e1a18},
      '{3'h6, 8'h7d, 32'h16120e0a, 32'h1c181412}, '{3'h7, 8'h7d, 32'h2e241c12, 32'h28231e18}};
   logic clk, rst_b, hsel, hwrite, hreadyout, hresp, top_pin, hit_pin;
   logic upper_switch_drive, lower_switch_drive, mon_on;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, rate_pin;
   logic [2:0] hsize, mode_pin;
   logic [7:0] cycle_energy, tgt;
   logic [15:0] top_gap;
   int miscompares = 0;
   int check_count = 0;
   llc_low_power_burst_sequencer #(.BURST_BASE_CYCLES(4000)) u_llc_low_power_burst_sequencer (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .node_top_pin(top_pin), .cap_sense_hit_pin(hit_pin),
      .mode_preset_pin(mode_pin), .burst_rate_preset_pin(rate_pin),
      .upper_switch_drive(upper_switch_drive), .lower_switch_drive(lower_switch_drive),
      .cycle_energy(cycle_energy));
   half_bridge_stage_model u_half_bridge_stage_model (
      .clk(clk), .upper_switch_drive(upper_switch_drive),
      .lower_switch_drive(lower_switch_drive), .top_gap(top_gap),
      .node_top_pin(top_pin), .cap_sense_hit_pin(hit_pin));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one single AHB-Lite transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {27'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wait_mode(input logic [1:0] md, input int step);
      bus(1'b0, llc_pkg::A_STATUS, 32'h0);
      for (int i = 0; i < 40 && rd[5:4] !== md; i++) begin
         repeat (step) @(posedge clk);
         bus(1'b0, llc_pkg::A_STATUS, 32'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // gate watcher: order and shape of the low-power cycle
   int up_len = 0;
   int since_top = 0;
   int tops = 0;
   int rise_gap = 0;
   logic up_q = 1'b0;
   logic lo_q = 1'b0;
   logic top_q = 1'b0;
   logic dumped = 1'b0;
   logic lo_in_wait = 1'b0;
   always @(posedge clk) begin
      top_q <= top_pin;
      up_q <= upper_switch_drive;
      lo_q <= lower_switch_drive;
      since_top <= (top_pin && !top_q) ? 0 : since_top + 1;
      up_len <= upper_switch_drive ? up_len + 1 : 0;
      if (top_pin && !top_q && dumped) tops <= tops + 1;
      if (lower_switch_drive && dumped) lo_in_wait <= 1'b1;
      if (upper_switch_drive && !up_q) rise_gap <= since_top;
      if (mon_on && !upper_switch_drive && up_q && up_len < 10) begin
         check("short upper pulse", up_len == 4 || up_len == 6, 1'b1);
         if (up_len == 4) begin
            dumped <= 1'b1;
            tops <= 0;
            lo_in_wait <= 1'b0;
         end
         if (up_len == 6) begin
            check("dump before restore", dumped, 1'b1);
            check("gates off in wait", lo_in_wait, 1'b0);
            check("tops in wait", tops > 0, 1'b1);
            check("restore on top", rise_gap < 8, 1'b1);
            // lower gate takes over on the same edge that ends the restore pulse
            check("gate after restore", {upper_switch_drive, lower_switch_drive}, 2'b01);
            dumped <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (95000) @(posedge clk);
      miscompares++;
      wrap_up;
   end
   initial begin
      {rst_b, hsel, hwrite, mon_on} = 4'h0;
      {haddr, hwdata, htrans, mode_pin, rate_pin} = '0;
      hsize = 3'h2;
      top_gap = 16'h0010;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check("gates after reset", {upper_switch_drive, lower_switch_drive, hresp}, 3'h0);
      bus(1'b1, 5'h14, 32'hffffffff);
      bus(1'b0, 5'h14, 32'h0);
      check("unmapped read", rd, 32'h0);
      // presets follow the pins at each start and ignore them while running
      for (int m = 0; m < 8; m++) begin
         for (int r = 0; r < 4; r++) begin
            mode_pin <= ROWS[m].mode;
            rate_pin <= 2'(r);
            repeat (4) @(posedge clk);
            bus(1'b1, llc_pkg::A_CTRL, 32'h1);
            repeat (8) @(posedge clk);
            mode_pin <= ~ROWS[m].mode;
            rate_pin <= ~2'(r);
            repeat (4) @(posedge clk);
            bus(1'b0, llc_pkg::A_PRESET, 32'h0);
            check("preset", rd, {6'h0, 2'(r), ROWS[m].ex[8*r +: 8], ROWS[m].ec[8*r +: 8],
               ROWS[m].thr});
            bus(1'b1, llc_pkg::A_CTRL, 32'h0);
         end
      end
      // low-power operation with preset code 0, rate code 0
      mode_pin <= 3'h0;
      rate_pin <= 2'h0;
      repeat (4) @(posedge clk);
      mon_on <= 1'b1;
      bus(1'b1, llc_pkg::A_DEMAND, 32'h28);
      bus(1'b1, llc_pkg::A_CTRL, 32'h1);
      repeat (400) @(posedge clk);
      bus(1'b0, llc_pkg::A_STATUS, 32'h0);
      check("energy submode", rd[5:4], llc_pkg::energy_control_submode);
      check("compensated energy", rd[15:8], 8'h3c);
      check("energy port", cycle_energy, 8'h3c);
      bus(1'b1, llc_pkg::A_DEMAND, 32'h14);
      repeat (400) @(posedge clk);
      check("energy follows demand", cycle_energy, 8'h1e);
      bus(1'b1, llc_pkg::A_DEMAND, 32'h3c);
      wait_mode(llc_pkg::continuous_switching_mode, 100);
      check("continuous above threshold", rd[5:4], llc_pkg::continuous_switching_mode);
      bus(1'b1, llc_pkg::A_DEMAND, 32'h0);
      wait_mode(llc_pkg::rate_control_submode, 100);
      check("rate submode", rd[5:4], llc_pkg::rate_control_submode);
      check("minimum energy", rd[15:8], 8'h0a);
      bus(1'b0, llc_pkg::A_WAIT, 32'h0);
      check("wait lengthened", rd[7:0] > 8'h01, 1'b1);
      repeat (1000) @(posedge clk);
      mon_on <= 1'b0;
      bus(1'b1, llc_pkg::A_CTRL, 32'h0);
      // slow resonance pushes the cycle rate below the grouped entry rate
      mode_pin <= 3'h7;
      rate_pin <= 2'h3;
      top_gap <= 16'h00c8;
      repeat (20) @(posedge clk);
      mon_on <= 1'b1;
      bus(1'b1, llc_pkg::A_CTRL, 32'h1);
      wait_mode(llc_pkg::grouped_pulse_mode, 500);
      check("grouped mode entered", rd[5:4], llc_pkg::grouped_pulse_mode);
      check("grouped energy", rd[15:8], 8'h2e);
      bus(1'b0, llc_pkg::A_WAIT, 32'h0);
      tgt = rd[7:0];
      bus(1'b1, llc_pkg::A_DEMAND, 32'h4);
      repeat (30000) @(posedge clk);
      bus(1'b0, llc_pkg::A_WAIT, 32'h0);
      check("wait frozen", rd[7:0], tgt);
      check("cycles per burst", rd[23:16], 8'h03);
      bus(1'b1, llc_pkg::A_DEMAND, 32'h30);
      wait_mode(llc_pkg::energy_control_submode, 500);
      check("grouped mode left", rd[5:4], llc_pkg::energy_control_submode);
      wrap_up;
   end
endmodule
